// ===== lbst_pkg.sv
// Package of register offsets, field layout, reset values and states for the strobe timer.
package lbst_pkg;

    // ========================================================================
    // Register map and field layout
    // ========================================================================
    localparam logic [7:0] OFS_TIMING_ONE = 8'h08;
    localparam logic [7:0] OFS_TIMING_TWO = 8'h0c;
    localparam int         FIELD_W        = 4;
    localparam int         RD_CS_ON_LSB   = 0;
    localparam int         RD_CS_OFF_LSB  = 4;
    localparam int         WR_CS_ON_LSB   = 8;
    localparam int         WR_CS_OFF_LSB  = 12;
    localparam int         RD_ON_LSB      = 16;
    localparam int         RD_OFF_LSB     = 20;
    localparam int         WR_ON_LSB      = 24;
    localparam int         WR_OFF_LSB     = 28;

    // ========================================================================
    // Reset values (normal local bus and parallel port mode)
    // ========================================================================
    localparam logic [31:0] TIMING_RST_LB = 32'h2030_2030;
    localparam logic [31:0] TIMING_RST_PP = 32'h2121_2020;

    // ========================================================================
    // Sequencing constants
    // ========================================================================
    localparam logic [3:0]  CNT_ZERO  = 4'h0;
    localparam logic [3:0]  CNT_ONE   = 4'h1;
    localparam logic [3:0]  CNT_LAST  = 4'ha;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

    // Sequencer states, Gray along idle, wait, run.
    typedef enum logic [1:0] {
        LBST_IDLE = 2'b00,
        LBST_WAIT = 2'b01,
        LBST_RUN  = 2'b11
    } lbst_state_t;

endpackage : lbst_pkg

// ===== lbst_cnt_if.sv
// Interface joining the strobe controller to its reference-cycle counter.
`timescale 1ns/1ps
interface lbst_cnt_if;
    logic       start;
    logic       run;
    logic [3:0] count;

    modport ctl (output start, input run, input count);
    modport cnt (input start, output run, output count);
endinterface : lbst_cnt_if

// ===== lbst_cnt.sv
// Reference-cycle counter: waits two cycles after a start, then counts cycles.
`timescale 1ns/1ps
module lbst_cnt (
    // Clock, reset and enable.
    input  wire logic  i_sys_clk,
    input  wire logic  i_srst,
    input  wire logic  i_ce,
    // Link to controller.
    lbst_cnt_if.cnt    cif
);

    lbst_pkg::lbst_state_t state_reg;
    lbst_pkg::lbst_state_t state_next;
    logic [3:0]            count_reg;
    logic [3:0]            count_next;

    // ========================================================================
    // Next state
    // ========================================================================
    // A start while a cycle runs is ignored; the master cannot overlap accesses.
    always_comb begin
        state_next = state_reg;
        count_next = count_reg;
        unique case (state_reg)
            lbst_pkg::LBST_IDLE: begin
                if (cif.start) begin
                    state_next = lbst_pkg::LBST_WAIT;
                end
            end
            lbst_pkg::LBST_WAIT: begin
                state_next = lbst_pkg::LBST_RUN; // R01
                count_next = lbst_pkg::CNT_ZERO; // R15
            end
            lbst_pkg::LBST_RUN: begin
                if (count_reg == lbst_pkg::CNT_LAST) begin
                    state_next = lbst_pkg::LBST_IDLE;
                end else begin
                    count_next = count_reg + lbst_pkg::CNT_ONE; // R15
                end
            end
            default: begin
                state_next = lbst_pkg::LBST_IDLE;
            end
        endcase
    end

    // Registers, frozen while the clock enable is low.
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            state_reg <= lbst_pkg::LBST_IDLE;
            count_reg <= lbst_pkg::CNT_ZERO;
        end else if (i_ce) begin
            state_reg <= state_next;
            count_reg <= count_next;
        end
    end

    assign cif.run   = (state_reg == lbst_pkg::LBST_RUN);
    assign cif.count = count_reg;

endmodule : lbst_cnt

// ===== lbst_top.sv
// Local bus strobe timing: timing register and control strobe generation.
//
// Summary of operation
// [R01] The reference cycle is the clock cycle two cycles after the master asserts IRDY.
// [R02] Each timing field is four bits counting clock cycles after the reference cycle.
// [R03] Separate-strobe reads drive the region selects low at the count in bits 3:0, reset 0h.
// [R04] Separate-strobe reads return region selects high at bits 7:4, reset 3h or 2h for parallel.
// [R05] Separate-strobe writes drive the region selects low at the count in bits 11:8, reset 0h.
// [R06] Bits 15:12, reset 2h, end selects on writes, or read-not-write in data-strobe style.
// [R07] Bits 19:16 set when read strobe or data strobes go low on reads, reset 0h or 1h.
// [R08] Bits 23:20 set when read strobe or data strobes go high on reads, reset 3h or 2h.
// [R09] Bits 27:24 set when write strobe or data strobes go low on writes, reset 0h or 1h.
// [R10] Bits 31:28, reset 2h, set when write strobe or data strobes go high on writes.
// [R11] In data-strobe style the three region select fields in bits 11:0 are ignored.
// [R12] Software programs only values 0h to Ah into each field; larger values are reserved.
// [R13] The same timing applies for 8-bit and 32-bit local bus data.
// [R14] The same timing applies to I/O accesses through BAR0 and memory accesses through BAR1.
// [R15] A counter clears at the reference cycle and each output toggles when it meets its field.
`timescale 1ns/1ps
module lbst_top (
    // Clock, reset and enable.
    input  wire logic        i_sys_clk,
    input  wire logic        i_srst,
    input  wire logic        i_ce,
    // Mode straps.
    input  wire logic        i_par_port_mode,
    input  wire logic        i_ds_style,
    // Register port.
    input  wire logic        i_reg_wr,
    input  wire logic [7:0]  i_reg_addr,
    input  wire logic [31:0] i_reg_wdata,
    output logic      [31:0] o_reg_rdata,
    // Access request from the target controller.
    input  wire logic        i_access_start,
    input  wire logic        i_access_write,
    input  wire logic [3:0]  i_region_sel,
    input  wire logic [3:0]  i_byte_en,
    // Local bus control pins.
    output logic      [3:0]  o_region_select_n,
    output logic             o_read_strobe_n,
    output logic             o_write_strobe_n,
    output logic      [3:0]  o_byte_data_strobe_n,
    output logic             o_read_not_write_n,
    output logic             o_busy
);

    localparam int FW = lbst_pkg::FIELD_W;

    lbst_cnt_if cif ();

    logic [31:0] timing_reg;
    logic [31:0] timing_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic        write_reg;
    logic        write_next;
    logic [3:0]  region_reg;
    logic [3:0]  region_next;
    logic [3:0]  bytes_reg;
    logic [3:0]  bytes_next;
    logic        sel_on_reg;
    logic        sel_on_next;
    logic        strb_on_reg;
    logic        strb_on_next;
    logic        rnw_on_reg;
    logic        rnw_on_next;
    logic        busy_reg;
    logic        busy_next;
    logic [3:0]  cs_on;
    logic [3:0]  cs_off;
    logic [3:0]  st_on;
    logic [3:0]  st_off;

    // ========================================================================
    // Reference-cycle counter
    // ========================================================================
    lbst_cnt u_cnt (
        .i_sys_clk (i_sys_clk),
        .i_srst    (i_srst),
        .i_ce      (i_ce),
        .cif       (cif.cnt)
    );

    // Both BAR paths raise the same start, so one timing set serves them. R14
    assign cif.start = i_access_start & ~busy_reg; // R01

    // ========================================================================
    // Timing register and readback
    // ========================================================================
    // Reserved field values are stored as written; they simply never match. R12
    always_comb begin
        timing_next = timing_reg;
        rdata_next  = lbst_pkg::WORD_ZERO;
        if (i_reg_wr && (i_reg_addr == lbst_pkg::OFS_TIMING_ONE)) begin
            timing_next = i_reg_wdata; // R02
        end
        if (i_reg_addr == lbst_pkg::OFS_TIMING_ONE) begin
            rdata_next = timing_reg;
        end
    end

    // Field selection per direction; one set whatever the data width. R13
    always_comb begin
        if (write_reg) begin
            cs_on  = timing_reg[lbst_pkg::WR_CS_ON_LSB +: FW];  // R05
            cs_off = timing_reg[lbst_pkg::WR_CS_OFF_LSB +: FW]; // R06
            st_on  = timing_reg[lbst_pkg::WR_ON_LSB +: FW];     // R09
            st_off = timing_reg[lbst_pkg::WR_OFF_LSB +: FW];    // R10
        end else begin
            cs_on  = timing_reg[lbst_pkg::RD_CS_ON_LSB +: FW];  // R03
            cs_off = timing_reg[lbst_pkg::RD_CS_OFF_LSB +: FW]; // R04
            st_on  = timing_reg[lbst_pkg::RD_ON_LSB +: FW];     // R07
            st_off = timing_reg[lbst_pkg::RD_OFF_LSB +: FW];    // R08
        end
    end

    // ========================================================================
    // Strobe sequencing
    // ========================================================================
    // De-assertion is tested after assertion so that equal fields leave a line idle.
    always_comb begin
        write_next   = write_reg;
        region_next  = region_reg;
        bytes_next   = bytes_reg;
        sel_on_next  = sel_on_reg;
        strb_on_next = strb_on_reg;
        rnw_on_next  = rnw_on_reg;
        busy_next    = busy_reg;
        if (cif.start) begin
            write_next  = i_access_write;
            region_next = i_region_sel;
            bytes_next  = i_byte_en;
            busy_next   = 1'b1;
        end
        if (cif.run) begin
            if (cif.count == cs_on) begin
                sel_on_next = 1'b1; // R15
            end
            if (cif.count == cs_off) begin
                sel_on_next = 1'b0; // R15
            end
            if (cif.count == st_on) begin
                strb_on_next = 1'b1; // R15
            end
            if (cif.count == st_off) begin
                strb_on_next = 1'b0; // R15
            end
            // Read-not-write goes low at the reference cycle of a write.
            if (write_reg && (cif.count == lbst_pkg::CNT_ZERO)) begin
                rnw_on_next = 1'b1;
            end
            if (cif.count == cs_off) begin
                rnw_on_next = 1'b0; // R06
            end
            // The last count closes every line, covering reserved field values.
            if (cif.count == lbst_pkg::CNT_LAST) begin
                sel_on_next  = 1'b0;
                strb_on_next = 1'b0;
                rnw_on_next  = 1'b0;
                busy_next    = 1'b0;
            end
        end
    end

    // Registers; the timing word reset value follows the parallel port strap.
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            timing_reg  <= i_par_port_mode ? lbst_pkg::TIMING_RST_PP
                                           : lbst_pkg::TIMING_RST_LB; // R04
            rdata_reg   <= lbst_pkg::WORD_ZERO;
            write_reg   <= 1'b0;
            region_reg  <= lbst_pkg::CNT_ZERO;
            bytes_reg   <= lbst_pkg::CNT_ZERO;
            sel_on_reg  <= 1'b0;
            strb_on_reg <= 1'b0;
            rnw_on_reg  <= 1'b0;
            busy_reg    <= 1'b0;
        end else if (i_ce) begin
            timing_reg  <= timing_next;
            rdata_reg   <= rdata_next;
            write_reg   <= write_next;
            region_reg  <= region_next;
            bytes_reg   <= bytes_next;
            sel_on_reg  <= sel_on_next;
            strb_on_reg <= strb_on_next;
            rnw_on_reg  <= rnw_on_next;
            busy_reg    <= busy_next;
        end
    end

    // ========================================================================
    // Pin outputs
    // ========================================================================
    // Pins are decoded from the next-state values into flops; each pin keeps its own flop.
    logic [3:0] cs_n_reg;
    logic [3:0] cs_n_next;
    logic [3:0] ds_n_reg;
    logic [3:0] ds_n_next;
    logic       rd_n_reg;
    logic       rd_n_next;
    logic       wr_n_reg;
    logic       wr_n_next;
    logic       rnw_n_reg;
    logic       rnw_n_next;

    // In data-strobe style the selects follow the data strobes instead. R11
    always_comb begin
        if (i_ds_style) begin
            cs_n_next  = ~(region_reg & {4{strb_on_next}}); // R11
            ds_n_next  = ~(bytes_reg & {4{strb_on_next}});
            rd_n_next  = 1'b1;
            wr_n_next  = 1'b1;
            rnw_n_next = ~rnw_on_next;
        end else begin
            cs_n_next  = ~(region_reg & {4{sel_on_next}});
            ds_n_next  = 4'hf;
            rd_n_next  = ~(strb_on_next & ~write_reg);
            wr_n_next  = ~(strb_on_next & write_reg);
            rnw_n_next = 1'b1;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            cs_n_reg  <= 4'hf;
            ds_n_reg  <= 4'hf;
            rd_n_reg  <= 1'b1;
            wr_n_reg  <= 1'b1;
            rnw_n_reg <= 1'b1;
        end else if (i_ce) begin
            cs_n_reg  <= cs_n_next;
            ds_n_reg  <= ds_n_next;
            rd_n_reg  <= rd_n_next;
            wr_n_reg  <= wr_n_next;
            rnw_n_reg <= rnw_n_next;
        end
    end

    assign o_region_select_n    = cs_n_reg;
    assign o_byte_data_strobe_n = ds_n_reg;
    assign o_read_strobe_n      = rd_n_reg;
    assign o_write_strobe_n     = wr_n_reg;
    assign o_read_not_write_n   = rnw_n_reg;
    assign o_reg_rdata          = rdata_reg;
    assign o_busy               = busy_reg;

endmodule : lbst_top

// ===== lbst_chk.sv
// Checker of pin timing relations for the strobe timer.
`timescale 1ns/1ps
module lbst_chk (
    // Clock and inputs.
    input wire logic        i_sys_clk,
    input wire logic        i_srst,
    input wire logic        i_ce,
    input wire logic        i_ds_style,
    input wire logic        i_reg_wr,
    input wire logic [7:0]  i_reg_addr,
    input wire logic [31:0] i_reg_wdata,
    input wire logic        i_access_start,
    input wire logic        i_access_write,
    input wire logic [3:0]  i_region_sel,
    // Observed outputs.
    input wire logic [31:0] o_reg_rdata,
    input wire logic [3:0]  o_region_select_n,
    input wire logic        o_read_strobe_n,
    input wire logic        o_write_strobe_n,
    input wire logic [3:0]  o_byte_data_strobe_n,
    input wire logic        o_read_not_write_n,
    input wire logic        o_busy
);
    // ========================================================================
    // Helper state
    // ========================================================================
    logic [3:0] cnt_reg, cnt_next;
    logic       wr_reg, wr_next;
    logic [3:0] rg_reg, rg_next;
    logic       quiet;

    // All control pins at their idle level.
    assign quiet = (&o_region_select_n) && o_read_strobe_n && o_write_strobe_n
                   && (&o_byte_data_strobe_n) && o_read_not_write_n;

    // Cycles since the taken start, plus the direction and region it carried.
    always_comb begin
        cnt_next = cnt_reg;
        wr_next  = wr_reg;
        rg_next  = rg_reg;
        if (i_ce && i_access_start && !o_busy) begin
            cnt_next = 4'h1;
            wr_next  = i_access_write;
            rg_next  = i_region_sel;
        end else if (i_ce && o_busy) begin
            cnt_next = cnt_reg + 4'h1;
        end
    end

    // Registers only; cleared with the design so nothing stale survives a reset.
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            cnt_reg <= 4'h0;
            wr_reg  <= 1'b0;
            rg_reg  <= 4'h0;
        end else begin
            cnt_reg <= cnt_next;
            wr_reg  <= wr_next;
            rg_reg  <= rg_next;
        end
    end

    // ========================================================================
    // Assertions
    // ========================================================================
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_srst);

    busy_start_a: assert property (i_ce && i_access_start && !o_busy |=> o_busy)
        else $error("busy did not rise after a start");
    busy_hold_a: assert property (o_busy && cnt_reg < 4'hc |=> o_busy)
        else $error("busy fell early");
    busy_end_a: assert property (o_busy && i_ce && cnt_reg == 4'hc |=> !o_busy)
        else $error("busy did not fall after twelve cycles");
    idle_quiet_a: assert property (!o_busy |-> quiet)
        else $error("control pin active while idle");
    ref_early_a: assert property (o_busy && cnt_reg <= 4'h2 |-> quiet)
        else $error("control pin active before the reference cycle");
    sep_unused_a: assert property (!i_ds_style
        |-> (&o_byte_data_strobe_n) && o_read_not_write_n)
        else $error("data strobe pin active in separate style");
    ds_unused_a: assert property (i_ds_style |-> o_read_strobe_n && o_write_strobe_n)
        else $error("read or write strobe active in data-strobe style");
    dir_read_a: assert property (o_busy && !wr_reg
        |-> o_write_strobe_n && o_read_not_write_n)
        else $error("write pin active during a read");
    dir_write_a: assert property (o_busy && wr_reg |-> o_read_strobe_n)
        else $error("read strobe active during a write");
    region_only_a: assert property (o_busy |-> (~o_region_select_n & ~rg_reg) == 4'h0)
        else $error("unselected region driven low");
    reg_read_a: assert property (i_reg_wr && i_reg_addr == 8'h08
        ##1 i_reg_addr == 8'h08 && !i_reg_wr |=> o_reg_rdata == $past(i_reg_wdata, 2))
        else $error("timing word read back wrong");
    unmapped_a: assert property (i_reg_addr != 8'h08 |=> o_reg_rdata == 32'h0000_0000)
        else $error("unmapped address read nonzero");

    // Main scenarios reached.
    cover property (i_access_start && !o_busy && i_access_write && i_ds_style);
    cover property (i_access_start && !o_busy && !i_access_write && !i_ds_style);
    cover property (i_access_start && o_busy);
endmodule : lbst_chk

bind lbst_top lbst_chk u_chk (.*);

// ===== lbst_periph.sv
// Behavioural peripheral on the local bus that counts select assertions.
`timescale 1ns/1ps
module lbst_periph (
    // Clock and local bus pins.
    input  wire logic       i_sys_clk,
    input  wire logic [3:0] i_region_select_n,
    output logic      [7:0] o_sel_cnt
);
    logic was_sel;

    // One transfer each time some select goes low after all were high; a glitch-free select is assumed.
    initial begin
        o_sel_cnt = 8'h00;
        was_sel   = 1'b0;
    end
    always @(posedge i_sys_clk) begin
        if (!(&i_region_select_n) && !was_sel) o_sel_cnt <= o_sel_cnt + 8'h01;
        was_sel <= !(&i_region_select_n);
    end
endmodule : lbst_periph

// ===== lbst_tb_top.sv
// Self-checking testbench of the strobe timer.
`timescale 1ns/1ps
module lbst_tb_top;
    // ========================================================================
    // Signals
    // ========================================================================
    logic        clk, srst, ce, par, ds, we, start, acc_wr;
    logic [7:0]  addr, sel_cnt;
    logic [31:0] wdata, rdata;
    logic [3:0]  acc_rg, acc_be, rsel_n, bds_n;
    logic        rd_n, wr_n, rnw_n, busy;
    logic [11:0] pins;
    int          err_total = 0;
    int          checked = 0;

    assign pins = {rsel_n, rd_n, wr_n, bds_n, rnw_n, busy};
    always #5 clk = ~clk;

    lbst_top DUT (.i_sys_clk(clk), .i_srst(srst), .i_ce(ce), .i_par_port_mode(par),
        .i_ds_style(ds), .i_reg_wr(we), .i_reg_addr(addr), .i_reg_wdata(wdata),
        .o_reg_rdata(rdata), .i_access_start(start), .i_access_write(acc_wr),
        .i_region_sel(acc_rg), .i_byte_en(acc_be), .o_region_select_n(rsel_n),
        .o_read_strobe_n(rd_n), .o_write_strobe_n(wr_n), .o_byte_data_strobe_n(bds_n),
        .o_read_not_write_n(rnw_n), .o_busy(busy));
    lbst_periph u_periph (.i_sys_clk(clk), .i_region_select_n(rsel_n), .o_sel_cnt(sel_cnt));

    // ========================================================================
    // Expectations and helpers
    // ========================================================================
    // Low in cycle j after start; reserved ends are cut at the forced end.
    function automatic logic lw(int j, logic [3:0] on, logic [3:0] off);
        int e;
        e = (off > 4'ha) ? 10 : int'(off);
        return (on <= 4'ha) && j >= 3 + on && j < 3 + e;
    endfunction : lw

    function automatic logic [11:0] exp_pins(int j, logic w, logic [3:0] rg,
                                             logic [3:0] be, logic [31:0] t);
        logic l, c, n, b;
        l = w ? lw(j, t[27:24], t[31:28]) : lw(j, t[19:16], t[23:20]);
        c = w ? lw(j, t[11:8], t[15:12]) : lw(j, t[3:0], t[7:4]);
        n = w && lw(j, 4'h0, t[15:12]);
        b = j >= 1 && j <= 12;
        if (ds) return {~(rg & {4{l}}), 2'b11, ~(be & {4{l}}), ~n, b};
        return {~(rg & {4{c}}), ~(l && !w), ~(l && w), 4'hf, 1'b1, b};
    endfunction : exp_pins

    task automatic cmp(string nm, logic [31:0] e, logic [31:0] g);
        checked++;
        if (g !== e) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : cmp

    task automatic finish_test;
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : finish_test

    task automatic do_reset(logic p);
        par  = p;
        srst = 1'b1;
        repeat (12) @(negedge clk);
        srst = 1'b0;
    endtask : do_reset

    task automatic wr_word(logic [31:0] d);
        we    = 1'b1;
        addr  = lbst_pkg::OFS_TIMING_ONE;
        wdata = d;
        @(negedge clk);
        we = 1'b0;
    endtask : wr_word

    task automatic chk_rd(string nm, logic [7:0] a, logic [31:0] e);
        addr = a;
        @(negedge clk);
        cmp(nm, e, rdata);
        $display("test %s done", nm);
    endtask : chk_rd

    // One access judged cycle by cycle; a start at cycle poke must be refused.
    task automatic run_acc(string nm, logic w, logic [3:0] rg, logic [3:0] be,
                           logic [31:0] t, int poke);
        logic [7:0]  c0;
        logic [11:0] x;
        logic        e;
        c0     = sel_cnt;
        e      = 1'b0;
        start  = 1'b1;
        acc_wr = w;
        acc_rg = rg;
        acc_be = be;
        for (int j = 1; j <= 13; j++) begin
            @(negedge clk);
            if (j < 13) start = (j == poke);
            x = exp_pins(j, w, rg, be, t);
            cmp(nm, 32'(x), 32'(pins));
            e |= (x[11:8] != 4'hf);
        end
        cmp({nm, " peripheral"}, 32'(c0 + 8'(e)), 32'(sel_cnt));
        $display("test %s done", nm);
    endtask : run_acc

    // ========================================================================
    // Main sequence and watchdog
    // ========================================================================
    initial begin
        {clk, srst, ce, par, ds, we, start, acc_wr} = 8'b0110_0000;
        {addr, wdata, acc_rg, acc_be} = '0;
        @(negedge clk);
        do_reset(1'b0);
        chk_rd("reset word", lbst_pkg::OFS_TIMING_ONE, 32'h2030_2030);
        chk_rd("unmapped", lbst_pkg::OFS_TIMING_TWO, lbst_pkg::WORD_ZERO);
        run_acc("sep read", 1'b0, 4'h1, 4'hf, lbst_pkg::TIMING_RST_LB, 0);
        run_acc("sep write", 1'b1, 4'h8, 4'hf, lbst_pkg::TIMING_RST_LB, 0);
        wr_word(32'h72A4_6183);
        chk_rd("readback", lbst_pkg::OFS_TIMING_ONE, 32'h72A4_6183);
        run_acc("refused start", 1'b0, 4'h4, 4'hf, 32'h72A4_6183, 5);
        run_acc("prog write", 1'b1, 4'h2, 4'hf, 32'h72A4_6183, 0);
        ds = 1'b1;
        run_acc("ds read", 1'b0, 4'h1, 4'h5, 32'h72A4_6183, 0);
        run_acc("ds write", 1'b1, 4'h2, 4'ha, 32'h72A4_6183, 0);
        ds = 1'b0;
        do_reset(1'b1);
        chk_rd("parallel word", lbst_pkg::OFS_TIMING_ONE, 32'h2121_2020);
        run_acc("pp read", 1'b0, 4'h1, 4'hf, lbst_pkg::TIMING_RST_PP, 0);
        run_acc("pp write", 1'b1, 4'h4, 4'hf, lbst_pkg::TIMING_RST_PP, 0);
        finish_test();
    end

    // About 134 cycles are needed; a hang is cut well after that.
    initial begin
        #5000;
        err_total++;
        finish_test();
    end
endmodule : lbst_tb_top
